// ---- rtl/dubp_defines.svh ----
// Constants of the dual UART host bus port
`ifndef DUBP_DEFINES_SVH
`define DUBP_DEFINES_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define DUBP_DATA_W      8
`define DUBP_ADDR_W      3
`define DUBP_PIN_W       16

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
// Pins idle: separate strobes, all strobes and selects high
`define DUBP_PINS_IDLE   16'hF800
`define DUBP_DATA_RST    8'h00
`define DUBP_ADDR_RST    3'h0
`define DUBP_CHAN_A      1'h0
`define DUBP_CHAN_B      1'h1
`define DUBP_STYLE_SEP   1'h1

`endif

// ---- rtl/dubp_pkg.sv ----
// Types of the dual UART host bus port
`include "dubp_defines.svh"

package dubp_pkg;

    // Host pins as sampled, one bundle
    typedef struct packed {
        logic                      style;
        logic                      read_strobe_n;
        logic                      write_strobe_n;
        logic                      chan_a_select_n;
        logic                      chan_b_select_n;
        logic [`DUBP_ADDR_W-1:0]   addr;
        logic [`DUBP_DATA_W-1:0]   data;
    } dubp_pins_t;

    // Register request toward the channel cores
    typedef struct packed {
        logic                      chan;
        logic [`DUBP_ADDR_W-1:0]   addr;
        logic [`DUBP_DATA_W-1:0]   wdata;
    } dubp_req_t;

    // Bus cycle state
    typedef enum logic [2:0] {
        DUBP_IDLE = 3'h1,
        DUBP_READ = 3'h2,
        DUBP_WRITE = 3'h4
    } dubp_state_t;

endpackage

// ---- rtl/dubp_port.sv ----
// Host parallel bus port of a dual channel UART
//
// Functional notes
// R1 - Style pin high selects separate strobes
// R2 - Read strobe fall reads addressed register
// R3 - Host captures read byte at strobe rise
// R4 - Write strobe rise loads bus byte
// R5 - Single-strobe style: read strobe tied high
// R6 - Single-strobe: write pin is direction
// R7 - Separate style: each select enables own channel
// R8 - Single-strobe: channel A select is chip select
// R9 - Single-strobe: channel B select picks channel
// R10 - Control bit one: irq A on, out-two low
// R11 - Control bit zero: irq A off, out-two high
// R12 - Channel B irq follows its control bit
// R13 - Single-strobe: irq A is open-drain device irq
// R14 - Transmit ready low-active per channel
// R15 - Receive ready low-active per channel
// R16 - Three address lines pick register
// R17 - Data bus driven only during reads
// R18 - Ready outputs from space and data present
// R19 - Unselected channel ignored, bus released
`timescale 1ns/1ns
`default_nettype none
`include "dubp_defines.svh"

module dubp_port (
    input  wire logic                      clk_sys,
    input  wire logic                      arst_n,
    input  wire logic                      bus_style_sel,
    input  wire logic                      read_strobe_n,
    input  wire logic                      write_strobe_n,
    input  wire logic                      chan_a_select_n,
    input  wire logic                      chan_b_select_n,
    input  wire logic [`DUBP_ADDR_W-1:0]   addr,
    input  wire logic [`DUBP_DATA_W-1:0]   data_in,
    output logic      [`DUBP_DATA_W-1:0]   data_out,
    output logic                           data_oe_n,
    output logic                           reg_rd_pulse,
    output logic                           reg_wr_pulse,
    output dubp_pkg::dubp_req_t            reg_req,
    input  wire logic [`DUBP_DATA_W-1:0]   reg_rdata_a,
    input  wire logic [`DUBP_DATA_W-1:0]   reg_rdata_b,
    input  wire logic                      op2_ctrl_a,
    input  wire logic                      op2_ctrl_b,
    input  wire logic                      irq_req_a,
    input  wire logic                      irq_req_b,
    input  wire logic                      tx_space_a,
    input  wire logic                      tx_space_b,
    input  wire logic                      rx_avail_a,
    input  wire logic                      rx_avail_b,
    output logic                           chan_a_irq,
    output logic                           chan_a_irq_oe_n,
    output logic                           chan_b_irq,
    output logic                           chan_b_irq_oe_n,
    output logic                           chan_a_user_out_two_n,
    output logic                           chan_b_user_out_two_n,
    output logic                           chan_a_tx_ready_n,
    output logic                           chan_b_tx_ready_n,
    output logic                           chan_a_rx_ready_n,
    output logic                           chan_b_rx_ready_n
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    dubp_pkg::dubp_pins_t pins_raw;
    dubp_pkg::dubp_pins_t pins_meta_q;
    dubp_pkg::dubp_pins_t pins_q;
    dubp_pkg::dubp_pins_t pins_prev_q;

    assign pins_raw = '{bus_style_sel, read_strobe_n, write_strobe_n,
                        chan_a_select_n, chan_b_select_n, addr, data_in};

    // Two stages before use; a third copy feeds the edge detectors
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pins_meta_q <= `DUBP_PINS_IDLE;
            pins_q      <= `DUBP_PINS_IDLE;
            pins_prev_q <= `DUBP_PINS_IDLE;
        end else begin
            pins_meta_q <= pins_raw;
            pins_q      <= pins_meta_q;
            pins_prev_q <= pins_q;
        end
    end

    // ---------------------------------------------------------------
    // Bus style decode
    // ---------------------------------------------------------------
    wire logic sep_style;
    wire logic sel_a;
    wire logic sel_b;
    wire logic sel_one;
    wire logic acc_rd;
    wire logic acc_wr;
    wire logic prev_acc_rd;
    wire logic prev_sep;
    wire logic prev_sel_one;

    // Separate strobes when the style pin is high
    assign sep_style = pins_q.style;                                     // see R1
    // Per-channel selects, or one select plus channel bit
    assign sel_a = sep_style ? !pins_q.chan_a_select_n                   // see R7
                             : (!pins_q.chan_a_select_n && !pins_q.chan_b_select_n); // see R8
    assign sel_b = sep_style ? !pins_q.chan_b_select_n
                             : (!pins_q.chan_a_select_n && pins_q.chan_b_select_n);  // see R9
    // Both selects low at once in separate style is a host fault; ignore it
    assign sel_one = sel_a ^ sel_b;                                      // see R19
    // Read: strobe low, or direction high in single-strobe style
    assign acc_rd = sel_one && (sep_style ? !pins_q.read_strobe_n        // see R2
                                          : pins_q.write_strobe_n);      // see R6
    assign acc_wr = sel_one && !pins_q.write_strobe_n;                   // see R4

    assign prev_sep     = pins_prev_q.style;
    assign prev_sel_one = prev_sep
                        ? (pins_prev_q.chan_a_select_n ^ pins_prev_q.chan_b_select_n)
                        : !pins_prev_q.chan_a_select_n;
    assign prev_acc_rd  = prev_sel_one && (prev_sep ? !pins_prev_q.read_strobe_n
                                                    : pins_prev_q.write_strobe_n);

    // ---------------------------------------------------------------
    // Bus cycle state machine
    // ---------------------------------------------------------------
    dubp_pkg::dubp_state_t state_q;
    dubp_pkg::dubp_state_t state_d;
    logic                  rd_start;
    logic                  wr_start;
    logic                  wr_done;

    // Only the falling edge starts a read, so a held strobe reads once
    assign rd_start = acc_rd && !prev_acc_rd;
    assign wr_start = acc_wr;
    assign wr_done  = (state_q == dubp_pkg::DUBP_WRITE) && !acc_wr;

    always_comb begin
        state_d = state_q;
        case (state_q)
            dubp_pkg::DUBP_IDLE: begin
                if (rd_start) begin
                    state_d = dubp_pkg::DUBP_READ;                       // see R2
                end else if (wr_start) begin
                    state_d = dubp_pkg::DUBP_WRITE;                      // see R4
                end
            end
            dubp_pkg::DUBP_READ: begin
                if (!acc_rd) begin
                    state_d = dubp_pkg::DUBP_IDLE;
                end
            end
            dubp_pkg::DUBP_WRITE: begin
                if (!acc_wr) begin
                    state_d = dubp_pkg::DUBP_IDLE;
                end
            end
            default: begin
                state_d = dubp_pkg::DUBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= dubp_pkg::DUBP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ---------------------------------------------------------------
    // Request capture toward the channel cores
    // ---------------------------------------------------------------
    logic rd_pend_q;

    // Channel and address latched at the start edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_req      <= '{`DUBP_CHAN_A, `DUBP_ADDR_RST, `DUBP_DATA_RST};
            reg_rd_pulse <= 1'h0;
            reg_wr_pulse <= 1'h0;
            rd_pend_q    <= 1'h0;
        end else begin
            reg_rd_pulse <= (state_q == dubp_pkg::DUBP_IDLE) && rd_start;
            reg_wr_pulse <= wr_done;                                     // see R4
            rd_pend_q    <= reg_rd_pulse;
            if ((state_q == dubp_pkg::DUBP_IDLE) && (rd_start || wr_start)) begin
                reg_req.chan <= sel_b;                                   // see R9
                reg_req.addr <= pins_q.addr;                             // see R16
            end
            // Last byte seen while the write is open is the one loaded
            if ((state_q == dubp_pkg::DUBP_WRITE) && acc_wr) begin
                reg_req.wdata <= pins_q.data;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read data and bus drive
    // ---------------------------------------------------------------
    wire logic [`DUBP_DATA_W-1:0] rdata_sel;

    assign rdata_sel = reg_req.chan ? reg_rdata_b : reg_rdata_a;

    // Core answers one cycle after the pulse; bus drives only in reads
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            data_out  <= `DUBP_DATA_RST;
            data_oe_n <= 1'h1;
        end else begin
            if (rd_pend_q) begin
                data_out <= rdata_sel;                                   // see R2
            end
            data_oe_n <= !((state_d == dubp_pkg::DUBP_READ) && !reg_rd_pulse
                           && (state_q == dubp_pkg::DUBP_READ));         // see R17
        end
    end

    // ---------------------------------------------------------------
    // Interrupt, output port and ready pins
    // ---------------------------------------------------------------
    // Separate style: control bit enables irq A; single: irq A open drain; irq B always enabled by its bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            chan_a_irq            <= 1'h0;
            chan_a_irq_oe_n       <= 1'h1;
            chan_b_irq            <= 1'h0;
            chan_b_irq_oe_n       <= 1'h1;
            chan_a_user_out_two_n <= 1'h1;
            chan_b_user_out_two_n <= 1'h1;
            chan_a_tx_ready_n     <= 1'h1;
            chan_b_tx_ready_n     <= 1'h1;
            chan_a_rx_ready_n     <= 1'h1;
            chan_b_rx_ready_n     <= 1'h1;
        end else begin
            chan_a_irq            <= sep_style && irq_req_a;
            chan_a_irq_oe_n       <= sep_style ? !op2_ctrl_a               // see R10 R11
                                               : !(irq_req_a || irq_req_b); // see R13
            chan_b_irq            <= irq_req_b;
            chan_b_irq_oe_n       <= !op2_ctrl_b;                          // see R12
            chan_a_user_out_two_n <= !op2_ctrl_a;                          // see R10 R11
            chan_b_user_out_two_n <= !op2_ctrl_b;                          // see R12
            chan_a_tx_ready_n     <= !tx_space_a;                          // see R14 R18
            chan_b_tx_ready_n     <= !tx_space_b;
            chan_a_rx_ready_n     <= !rx_avail_a;                          // see R15 R18
            chan_b_rx_ready_n     <= !rx_avail_b;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking dubp_cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_read_start_pulse: assert property (                                   // see R2 R16
        (state_q == dubp_pkg::DUBP_IDLE) && acc_rd && !prev_acc_rd
        |=> reg_rd_pulse && (reg_req.addr == $past(pins_q.addr)))
        else $error("read start gave no register read pulse");
    a_write_end_load: assert property (                                     // see R4
        (state_q == dubp_pkg::DUBP_WRITE) && !acc_wr |=> reg_wr_pulse && !reg_rd_pulse)
        else $error("write end gave no register write pulse");
    a_bus_idle_release: assert property (                                   // see R17
        !acc_rd |=> data_oe_n)
        else $error("data bus driven outside a read");
    a_unselected_quiet: assert property (                                   // see R19
        !sel_one && (state_q == dubp_pkg::DUBP_IDLE) |=> !reg_rd_pulse ##1 !reg_wr_pulse)
        else $error("unselected access produced a request");
    a_single_chan_bit: assert property (                                    // see R9
        !sep_style && (state_q == dubp_pkg::DUBP_IDLE) && rd_start
        |=> reg_req.chan == $past(pins_q.chan_b_select_n))
        else $error("channel bit not taken from channel B select");
    a_op2_follow_a: assert property (                                       // see R10
        sep_style && op2_ctrl_a && $stable(sep_style) |=> !chan_a_irq_oe_n && !chan_a_user_out_two_n)
        else $error("control bit A one did not enable irq A");
    a_op2_off_b: assert property (                                          // see R12
        !op2_ctrl_b |=> chan_b_irq_oe_n && chan_b_user_out_two_n)
        else $error("control bit B zero left irq B driven");
    a_open_drain_irq: assert property (                                     // see R13
        !sep_style && (irq_req_a || irq_req_b) |=> !chan_a_irq_oe_n && !chan_a_irq)
        else $error("device irq not pulled low");
    a_ready_pins: assert property (                                         // see R14
        tx_space_a && rx_avail_b |=> !chan_a_tx_ready_n && !chan_b_rx_ready_n)
        else $error("ready outputs do not follow channel state");
    a_read_drive_data: assert property (                                    // see R2
        reg_rd_pulse ##1 acc_rd ##1 acc_rd |=> !data_oe_n)
        else $error("read did not drive the data bus");

    c_sep_read: cover property (sep_style && reg_rd_pulse);
    c_sep_write: cover property (sep_style && reg_wr_pulse);
    c_single_read_b: cover property (!sep_style && reg_rd_pulse && reg_req.chan);
    c_single_write: cover property (!sep_style && reg_wr_pulse);

endmodule
`default_nettype wire

// ---- testbench/dubp_host_model.sv ----
// Host processor model driving the parallel bus pins of the port
`timescale 1ns/1ns
`default_nettype none
`include "dubp_defines.svh"

module dubp_host_model (
    input  wire logic                      clk_sys,
    output logic                           bus_style_sel,
    output logic                           read_strobe_n,
    output logic                           write_strobe_n,
    output logic                           chan_a_select_n,
    output logic                           chan_b_select_n,
    output logic      [`DUBP_ADDR_W-1:0]   addr,
    output logic      [`DUBP_DATA_W-1:0]   data_in,
    input  wire logic [`DUBP_DATA_W-1:0]   data_out,
    input  wire logic                      data_oe_n
);
    logic                      host_drive;
    logic [`DUBP_DATA_W-1:0]   host_data;
    logic [`DUBP_DATA_W-1:0]   last_bus = `DUBP_DATA_RST;

    // Idle pins: separate strobes, nothing selected
    initial begin
        {bus_style_sel, read_strobe_n, write_strobe_n} = 3'h7;
        {chan_a_select_n, chan_b_select_n} = 2'h3;
        addr = `DUBP_ADDR_RST;
        {host_drive, host_data} = 9'h000;
    end

    // No pull on the bus, so a released bus shows the inverse of its last value
    always @(posedge clk_sys) begin
        if (host_drive || !data_oe_n)
            last_bus <= data_in;
    end
    assign data_in = !data_oe_n ? data_out : host_drive ? host_data : ~last_bus;

    // Style change; wait out the two sync stages
    task automatic set_style(input logic sep);
        @(posedge clk_sys);
        #1;
        bus_style_sel = sep;
        read_strobe_n = 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    // One byte access; sel_mode 0 normal, 1 both selects low (separate style only), 2 none selected
    task automatic access(input logic sep, input logic chan, input logic wr,
                          input logic [2:0] a, input logic [7:0] wd,
                          input int sel_mode, output logic [7:0] rd);
        @(posedge clk_sys);
        #1;
        addr = a;
        host_data = wd;
        host_drive = wr;
        if (sep) begin
            chan_a_select_n = (sel_mode == 1) ? 1'b0 : (sel_mode == 2) | chan;
            chan_b_select_n = (sel_mode == 1) ? 1'b0 : (sel_mode == 2) | !chan;
        end else begin
            write_strobe_n = !wr;
            chan_b_select_n = chan;
        end
        @(posedge clk_sys);
        #1;
        if (!sep)
            chan_a_select_n = (sel_mode == 2);
        else if (wr)
            write_strobe_n = 1'b0;
        else
            read_strobe_n = 1'b0;
        // Strobe held well past the five cycles read data needs
        repeat (8) @(posedge clk_sys);
        rd = data_in;
        #1;
        if (sep)
            {read_strobe_n, write_strobe_n} = 2'h3;
        else
            chan_a_select_n = 1'b1;
        @(posedge clk_sys);
        #1;
        {write_strobe_n, chan_a_select_n, chan_b_select_n, host_drive} = 4'hE;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ---- testbench/dual_uart_host_bus_port_test.sv ----
// Self-checking testbench of the dual UART host bus port
`timescale 1ns/1ns
`default_nettype none
`include "dubp_defines.svh"

module dual_uart_host_bus_port_test;
    localparam int CYC_LIMIT = 3000;
    logic clk_sys, arst_n, bus_style_sel, read_strobe_n, write_strobe_n;
    logic chan_a_select_n, chan_b_select_n, data_oe_n, reg_rd_pulse, reg_wr_pulse;
    logic [2:0] addr;
    logic [7:0] data_in, data_out, reg_rdata_a, reg_rdata_b;
    logic op2_ctrl_a, op2_ctrl_b, irq_req_a, irq_req_b;
    logic tx_space_a, tx_space_b, rx_avail_a, rx_avail_b;
    logic chan_a_irq, chan_a_irq_oe_n, chan_b_irq, chan_b_irq_oe_n;
    logic chan_a_user_out_two_n, chan_b_user_out_two_n, chan_a_tx_ready_n;
    logic chan_b_tx_ready_n, chan_a_rx_ready_n, chan_b_rx_ready_n;
    dubp_pkg::dubp_req_t reg_req, last_req;
    int error_cnt = 0, checks = 0, cyc = 0, rd_cnt = 0, wr_cnt = 0, seed_val;

    dubp_port DUT (.clk_sys, .arst_n, .bus_style_sel, .read_strobe_n, .write_strobe_n,
        .chan_a_select_n, .chan_b_select_n, .addr, .data_in, .data_out, .data_oe_n,
        .reg_rd_pulse, .reg_wr_pulse, .reg_req, .reg_rdata_a, .reg_rdata_b, .op2_ctrl_a,
        .op2_ctrl_b, .irq_req_a, .irq_req_b, .tx_space_a, .tx_space_b, .rx_avail_a,
        .rx_avail_b, .chan_a_irq, .chan_a_irq_oe_n, .chan_b_irq, .chan_b_irq_oe_n,
        .chan_a_user_out_two_n, .chan_b_user_out_two_n, .chan_a_tx_ready_n,
        .chan_b_tx_ready_n, .chan_a_rx_ready_n, .chan_b_rx_ready_n);

    dubp_host_model HOST (.clk_sys, .bus_style_sel, .read_strobe_n, .write_strobe_n,
        .chan_a_select_n, .chan_b_select_n, .addr, .data_in, .data_out, .data_oe_n);

    // ---------------------------------------------------------------
    // Compare and report
    // ---------------------------------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_req(input string what, input dubp_pkg::dubp_req_t exp,
                           input dubp_pkg::dubp_req_t got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Status pins expected from the core levels and the bus style
    function automatic logic [7:0] exp_status(input logic sep);
        return {sep ? !op2_ctrl_a : !(irq_req_a | irq_req_b), !op2_ctrl_b, !op2_ctrl_a,
                !op2_ctrl_b, !tx_space_a, !tx_space_b, !rx_avail_a, !rx_avail_b};
    endfunction

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic run_access(input logic sep, input logic chan, input logic wr,
                              input logic [2:0] a, input int sel_mode);
        logic [7:0] wd;
        logic [7:0] rd;
        int rd0;
        int wr0;
        dubp_pkg::dubp_req_t exp_req;
        dubp_pkg::dubp_req_t got_req;
        @(posedge clk_sys);
        #1;
        wd = 8'($urandom);
        {reg_rdata_a, reg_rdata_b} = 16'($urandom);
        rd0 = rd_cnt;
        wr0 = wr_cnt;
        HOST.access(sep, chan, wr, a, wd, sel_mode, rd);
        chk_bit("read request", 1'b1, rd_cnt == rd0 + (sel_mode == 0 && !wr));
        chk_bit("write request", 1'b1, wr_cnt == wr0 + (sel_mode == 0 && wr));
        chk_bit("bus released", 1'b1, data_oe_n);
        if (sel_mode == 0) begin
            exp_req = '{chan: chan, addr: a, wdata: wr ? wd : 8'h00};
            got_req = last_req;
            if (!wr)
                got_req.wdata = 8'h00;
            chk_req("request", exp_req, got_req);
            if (!wr)
                chk_byte("read data", chan ? reg_rdata_b : reg_rdata_a, rd);
        end
    endtask

    task automatic run_status(input logic sep);
        logic [7:0] got;
        @(posedge clk_sys);
        #1;
        {op2_ctrl_a, op2_ctrl_b, irq_req_a, irq_req_b} = 4'($urandom);
        {tx_space_a, tx_space_b, rx_avail_a, rx_avail_b} = 4'($urandom);
        repeat (3) @(posedge clk_sys);
        #1;
        got = {chan_a_irq_oe_n, chan_b_irq_oe_n, chan_a_user_out_two_n, chan_b_user_out_two_n,
               chan_a_tx_ready_n, chan_b_tx_ready_n, chan_a_rx_ready_n, chan_b_rx_ready_n};
        chk_byte("status pins", exp_status(sep), got);
        if (!sep || op2_ctrl_a)
            chk_bit("irq a level", sep & irq_req_a, chan_a_irq);
        if (op2_ctrl_b)
            chk_bit("irq b level", irq_req_b, chan_b_irq);
    endtask

    // Clock at 125 MHz
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Count core requests and keep the last one for comparison
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (reg_rd_pulse === 1'b1)
            rd_cnt <= rd_cnt + 1;
        if (reg_wr_pulse === 1'b1)
            wr_cnt <= wr_cnt + 1;
        if (reg_rd_pulse === 1'b1 || reg_wr_pulse === 1'b1)
            last_req <= reg_req;
    end

    // Hang guard, well above the length of the sequence
    always @(posedge clk_sys) begin
        if (cyc == CYC_LIMIT) begin
            error_cnt++;
            $display("mismatch timeout expected %0d seen %0d", CYC_LIMIT, cyc);
            print_verdict;
        end
    end

    // Main sequence: corners of each style, refusals, then random traffic
    initial begin
        seed_val = $urandom(56);
        arst_n = 1'h0;
        {reg_rdata_a, reg_rdata_b, op2_ctrl_a, op2_ctrl_b, irq_req_a, irq_req_b} = 20'h00000;
        {tx_space_a, tx_space_b, rx_avail_a, rx_avail_b} = 4'h0;
        // Look after two edges: the reset fall at time zero may race the flops
        repeat (2) @(posedge clk_sys);
        #1;
        chk_byte("reset pins", 8'hFF, {data_oe_n, chan_a_irq_oe_n, chan_b_irq_oe_n,
                 chan_a_user_out_two_n, chan_b_user_out_two_n, chan_a_tx_ready_n,
                 chan_b_tx_ready_n, chan_a_rx_ready_n});
        chk_byte("reset data", `DUBP_DATA_RST, data_out);
        arst_n = 1'h1;
        repeat (3) @(posedge clk_sys);
        for (int s = 1; s >= 0; s--) begin
            HOST.set_style(s[0]);
            for (int k = 0; k < 4; k++)
                run_access(s[0], k[0], k[1], (k[0] ^ k[1]) ? 3'h7 : 3'h0, 0);
            run_access(s[0], 1'b0, 1'b0, 3'h5, 2);
            run_access(s[0], 1'b1, 1'b1, 3'h2, 2);
            if (s == 1) begin
                run_access(1'b1, 1'b0, 1'b0, 3'h1, 1);
                run_access(1'b1, 1'b1, 1'b1, 3'h6, 1);
            end
            for (int k = 0; k < 8; k++)
                run_access(s[0], 1'($urandom), 1'($urandom), 3'($urandom), 0);
            for (int k = 0; k < 6; k++)
                run_status(s[0]);
        end
        print_verdict;
    end
endmodule
`default_nettype wire
